// >>> hw/asb_pkg.sv
// shared constants and types of the scan buffer sequencer
package asb_pkg;
    localparam int unsigned DATA_W          = 10;
    localparam int unsigned NUM_RES         = 8;
    localparam int unsigned ADDR_W          = 8;

    localparam logic [7:0]  CSR_OFFSET      = 8'h00;
    localparam logic [7:0]  RES_BASE        = 8'h20;
    localparam logic [2:0]  RES_PAGE        = 3'h1;

    localparam int unsigned CSR_START_BIT   = 0;
    localparam int unsigned CSR_FLAG_BIT    = 1;
    localparam int unsigned CSR_IE_BIT      = 2;
    localparam int unsigned CSR_SCAN_BIT    = 3;
    localparam int unsigned CSR_GROUP_BIT   = 4;
    localparam int unsigned CSR_TRIG_BIT    = 5;
    localparam int unsigned CSR_BUF_LSB     = 6;
    localparam int unsigned CSR_CH_LSB      = 8;
    localparam int unsigned CSR_BUSY_BIT    = 11;
    localparam int unsigned CSR_HOLD_BIT    = 12;
    localparam int unsigned CSR_COUNT_LSB   = 13;

    localparam logic [1:0]  BUF_NONE        = 2'h0;
    localparam logic [1:0]  BUF_TWO_ONE     = 2'h1;
    localparam logic [1:0]  BUF_TWO_TWO     = 2'h2;
    localparam logic [1:0]  BUF_FOUR        = 2'h3;

    localparam logic [1:0]  BUF_RESET       = 2'h0;
    localparam logic [2:0]  CH_RESET        = 3'h0;
    localparam logic [2:0]  COUNT_RESET     = 3'h0;
    localparam logic [DATA_W-1:0] RES_RESET = 10'h000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_REQ,
        ST_WAIT,
        ST_HOLD
    } asb_state_type;
endpackage

// >>> hw/asb_result_bank.sv
// eight result registers with the selectable shift chains
`timescale 1ns/10ps
module asb_result_bank
    import asb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wr_en,
    input  wire logic [2:0]        wr_index,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              shift_en,
    input  wire logic [1:0]        buffer_mode,
    input  wire logic [2:0]        rd_index,
    output logic      [DATA_W-1:0] rd_data
);
    typedef struct packed {
        logic [NUM_RES-1:0][DATA_W-1:0] res;
    } asb_bank_type;

    asb_bank_type r;
    asb_bank_type n;

    always_comb begin
        n = r;
        if (wr_en) begin
            if (shift_en) begin
                unique case (buffer_mode)
                    BUF_TWO_ONE: n.res[1] = r.res[0];
                    BUF_TWO_TWO: n.res[wr_index + 3'h2] = r.res[wr_index];
                    BUF_FOUR: begin
                        n.res[3] = r.res[2];
                        n.res[2] = r.res[1];
                        n.res[1] = r.res[0];
                    end
                    BUF_NONE: n.res = r.res;
                endcase
            end
            n.res[wr_index] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r.res <= '{default: RES_RESET};
        end else begin
            r <= n;
        end
    end

    assign rd_data = r.res[rd_index];
endmodule // asb_result_bank

// >>> hw/asb_seq_decode.sv
// channel order, buffer shift and flag point of one conversion pass
`timescale 1ns/10ps
module asb_seq_decode
    import asb_pkg::*;
(
    input  wire logic       group_mode_select,
    input  wire logic [1:0] buffer_mode,
    input  wire logic [2:0] channel_select,
    input  wire logic [2:0] step,
    output logic      [2:0] chan,
    output logic            shift_en,
    output logic            last_step,
    output logic      [2:0] passes_needed,
    output logic      [2:0] flag_reg,
    output logic            invalid
);
    logic       buffered;
    logic       combined;
    logic       two_one_high;
    logic [2:0] nbase;
    logic [2:0] first_extra;
    logic [2:0] last_chan;

    always_comb begin
        buffered      = buffer_mode != BUF_NONE;
        two_one_high  = buffer_mode == BUF_TWO_ONE && channel_select[1];
        combined      = buffered && group_mode_select && (channel_select[2] || two_one_high);
        nbase         = (buffer_mode == BUF_TWO_TWO) ? 3'h2 : 3'h1;
        first_extra   = (buffer_mode == BUF_TWO_ONE) ? 3'h2 : 3'h4;
        invalid       = buffered && !combined && (channel_select[2] || two_one_high);
        passes_needed = 3'h1;
        shift_en      = 1'b0;
        last_chan     = CH_RESET;
        if (!buffered) begin
            chan      = group_mode_select ? step : channel_select;
            last_step = group_mode_select ? (step == channel_select) : 1'b1;
            flag_reg  = channel_select;
        end else begin
            shift_en  = step < nbase;
            chan      = shift_en ? step : 3'(first_extra + step - nbase);
            last_chan = combined ? channel_select : 3'(nbase - 3'h1);
            last_step = chan == last_chan;
            if (combined) begin
                flag_reg = channel_select;
            end else if (buffer_mode == BUF_TWO_TWO) begin
                passes_needed = {2'h0, channel_select[1]} + 3'h1;
                flag_reg      = channel_select[1] ? 3'h3 : 3'h1;
            end else begin
                passes_needed = {1'b0, channel_select[1:0]} + 3'h1;
                flag_reg      = {1'b0, channel_select[1:0]};
            end
        end
    end
endmodule // asb_seq_decode

// >>> hw/asb_top.sv
// converter sequencer with control/status register and buffered results on apb
// Functional notes
// - group scan repeats until start bit cleared
// - group scan without buffering flags after first full pass
// - scan with enable: interrupt, hold until cleared
// - flag clears by status read then zero write
// - new result in first, old shifts on
// - three chains: A-B, A-C/B-D, A-B-C-D
// - buffer field 00 none, 01, 10, 11
// - buffer alone needs no group; channel picks count
// - flag at pattern end; single stops, scan continues
// - flag rise with enable gives interrupt
// - select single buffer: standby each pass
// - mode 01 counts one or two passes, mode 11 one to four
// - combined: result goes to its input register
// - mode 01 combined adds inputs two upward
// - modes 10/11 combined add inputs four upward
// - transfer controller read of flag point clears
// - writing 00 while idle zeroes pass count
// - new buffer pattern taken at next start
`timescale 1ns/10ps
module asb_top
    import asb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire logic              timer_trigger,
    input  wire logic              xfer_ctrl_active,
    output logic                   conv_start,
    output logic      [2:0]        conv_channel,
    input  wire logic              conv_done,
    input  wire logic [DATA_W-1:0] conv_result,
    output logic                   conversion_end_interrupt
);
    typedef struct packed {
        asb_state_type state;
        logic          conversion_start_bit;
        logic          conversion_end_flag;
        logic          end_interrupt_enable;
        logic          scan_mode;
        logic          group_mode_select;
        logic          timer_start_select;
        logic [1:0]    buffer_mode;
        logic [2:0]    channel_select;
        logic          cfg_group;
        logic          cfg_scan;
        logic          cfg_trig;
        logic [1:0]    cfg_buffer;
        logic [2:0]    cfg_channel;
        logic          clear_armed;
        logic [2:0]    step;
        logic [2:0]    pass_count;
        logic          conv_start;
        logic [2:0]    conv_channel;
        logic [31:0]   prdata;
        logic          pslverr;
    } asb_core_type;

    asb_core_type r;
    asb_core_type n;
    logic [1:0]   rst_sync_q;
    logic         rst_n;

    logic              setup_phase;
    logic              access_phase;
    logic              wr_csr;
    logic              rd_csr;
    logic              rd_res;
    logic              clear_flag;
    logic              set_flag;
    logic              pass_end;
    logic              flag_hit;
    logic [2:0]        next_count;
    logic [31:0]       csr_value;
    logic [DATA_W-1:0] bank_rd;
    logic              bank_wr;
    logic [2:0]        dec_chan;
    logic              dec_shift;
    logic              dec_last;
    logic [2:0]        dec_passes;
    logic [2:0]        dec_flag_reg;
    logic              dec_invalid;

    function automatic logic hits_csr(input logic [ADDR_W-1:0] addr);
        hits_csr = addr == CSR_OFFSET;
    endfunction

    function automatic logic hits_res(input logic [ADDR_W-1:0] addr);
        hits_res = addr[7:5] == RES_PAGE && addr[1:0] == 2'h0;
    endfunction

    // reset enters asynchronously, released through two stages
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // decode follows the configuration latched at start, not the live fields
    asb_seq_decode u_decode (
        .group_mode_select (r.cfg_group),
        .buffer_mode       (r.cfg_buffer),
        .channel_select    (r.cfg_channel),
        .step              (r.step),
        .chan              (dec_chan),
        .shift_en          (dec_shift),
        .last_step         (dec_last),
        .passes_needed     (dec_passes),
        .flag_reg          (dec_flag_reg),
        .invalid           (dec_invalid)
    );

    assign bank_wr = r.state == ST_WAIT && conv_done;

    asb_result_bank u_bank (
        .clk         (clk),
        .rst_n       (rst_n),
        .wr_en       (bank_wr),
        .wr_index    (r.conv_channel),
        .wr_data     (conv_result),
        .shift_en    (dec_shift),
        .buffer_mode (r.cfg_buffer),
        .rd_index    (paddr[4:2]),
        .rd_data     (bank_rd)
    );

    always_comb begin
        csr_value                               = 32'h0000_0000;
        csr_value[CSR_START_BIT]                = r.conversion_start_bit;
        csr_value[CSR_FLAG_BIT]                 = r.conversion_end_flag;
        csr_value[CSR_IE_BIT]                   = r.end_interrupt_enable;
        csr_value[CSR_SCAN_BIT]                 = r.scan_mode;
        csr_value[CSR_GROUP_BIT]                = r.group_mode_select;
        csr_value[CSR_TRIG_BIT]                 = r.timer_start_select;
        csr_value[CSR_BUF_LSB+:2]               = r.buffer_mode;
        csr_value[CSR_CH_LSB+:3]                = r.channel_select;
        csr_value[CSR_BUSY_BIT]                 = r.state != ST_IDLE;
        csr_value[CSR_HOLD_BIT]                 = r.state == ST_HOLD;
        csr_value[CSR_COUNT_LSB+:3]             = r.pass_count;
    end

    always_comb begin
        n            = r;
        n.conv_start = 1'b0;
        setup_phase  = psel && !penable;
        access_phase = psel && penable;
        wr_csr       = access_phase && pwrite && hits_csr(paddr);
        rd_csr       = access_phase && !pwrite && hits_csr(paddr);
        rd_res       = access_phase && !pwrite && hits_res(paddr);
        clear_flag   = 1'b0;
        set_flag     = 1'b0;
        pass_end     = 1'b0;
        flag_hit     = 1'b0;
        next_count   = r.pass_count;

        // read data is captured in the setup cycle so the access cycle needs no wait
        if (setup_phase) begin
            n.pslverr = !(hits_csr(paddr) || hits_res(paddr)) || (pwrite && hits_res(paddr));
            if (hits_csr(paddr)) begin
                n.prdata = csr_value;
            end else if (hits_res(paddr)) begin
                n.prdata = {22'h0, bank_rd};
            end else begin
                n.prdata = 32'h0000_0000;
            end
        end

        if (rd_csr && r.conversion_end_flag) begin
            n.clear_armed = 1'b1;
        end
        if (rd_res && xfer_ctrl_active && r.conversion_end_flag && paddr[4:2] == dec_flag_reg) begin
            clear_flag = 1'b1;
        end

        if (wr_csr) begin
            n.clear_armed = 1'b0;
            if (!pwdata[CSR_FLAG_BIT] && r.clear_armed) begin
                clear_flag = 1'b1;
            end
            n.end_interrupt_enable = pwdata[CSR_IE_BIT];
            n.scan_mode            = pwdata[CSR_SCAN_BIT];
            n.group_mode_select    = pwdata[CSR_GROUP_BIT];
            n.timer_start_select   = pwdata[CSR_TRIG_BIT];
            n.buffer_mode          = pwdata[CSR_BUF_LSB+:2];
            n.channel_select       = pwdata[CSR_CH_LSB+:3];
            if (pwdata[CSR_BUF_LSB+:2] == BUF_NONE && r.state == ST_IDLE) begin
                n.pass_count = COUNT_RESET;
            end
            if (!pwdata[CSR_START_BIT]) begin
                // a stop abandons any conversion in flight
                n.conversion_start_bit = 1'b0;
                n.state                = ST_IDLE;
            end else if (!r.conversion_start_bit && r.state == ST_IDLE) begin
                n.conversion_start_bit = 1'b1;
                n.cfg_group            = pwdata[CSR_GROUP_BIT];
                n.cfg_scan             = pwdata[CSR_SCAN_BIT];
                n.cfg_trig             = pwdata[CSR_TRIG_BIT];
                n.cfg_buffer           = pwdata[CSR_BUF_LSB+:2];
                n.cfg_channel          = pwdata[CSR_CH_LSB+:3];
                n.state                = ST_ARM;
            end
        end

        if (!wr_csr || pwdata[CSR_START_BIT]) begin
            unique case (r.state)
                ST_IDLE: begin
                    n.step = 3'h0;
                end
                ST_ARM: begin
                    // a code outside the tables never starts, the start bit drops
                    if (dec_invalid) begin
                        n.conversion_start_bit = 1'b0;
                        n.state                = ST_IDLE;
                    end else if (!r.cfg_trig || timer_trigger) begin
                        n.step  = 3'h0;
                        n.state = ST_REQ;
                    end
                end
                ST_REQ: begin
                    n.conv_start   = 1'b1;
                    n.conv_channel = dec_chan;
                    n.state        = ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done) begin
                        if (dec_last) begin
                            pass_end = 1'b1;
                        end else begin
                            n.step  = r.step + 3'h1;
                            n.state = ST_REQ;
                        end
                    end
                end
                ST_HOLD: begin
                    // conversion resumes only once the flag is down again
                    if (!r.conversion_end_flag) begin
                        n.step  = 3'h0;
                        n.state = ST_REQ;
                    end
                end
            endcase
        end

        if (pass_end) begin
            if (r.cfg_buffer == BUF_NONE) begin
                flag_hit = 1'b1;
            end else begin
                next_count = r.pass_count + 3'h1;
                flag_hit   = next_count >= dec_passes;
            end
            n.pass_count = flag_hit ? COUNT_RESET : next_count;
            set_flag     = flag_hit;
            n.step       = 3'h0;
            if (r.cfg_scan) begin
                // scan keeps shifting through the chain unless the interrupt holds it
                n.state = (flag_hit && r.end_interrupt_enable) ? ST_HOLD : ST_REQ;
            end else if (flag_hit || !r.cfg_group) begin
                // select single with buffering parks after every pass, count kept until the flag pass zeroes it
                n.conversion_start_bit = 1'b0;
                n.state                = ST_IDLE;
            end else begin
                n.state = ST_REQ;
            end
        end

        // a flag event in the clearing cycle is kept
        if (clear_flag) begin
            n.conversion_end_flag = 1'b0;
        end
        if (set_flag) begin
            n.conversion_end_flag = 1'b1;
            n.clear_armed         = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r.state                <= ST_IDLE;
            r.conversion_start_bit <= 1'b0;
            r.conversion_end_flag  <= 1'b0;
            r.end_interrupt_enable <= 1'b0;
            r.scan_mode            <= 1'b0;
            r.group_mode_select    <= 1'b0;
            r.timer_start_select   <= 1'b0;
            r.buffer_mode          <= BUF_RESET;
            r.channel_select       <= CH_RESET;
            r.cfg_group            <= 1'b0;
            r.cfg_scan             <= 1'b0;
            r.cfg_trig             <= 1'b0;
            r.cfg_buffer           <= BUF_RESET;
            r.cfg_channel          <= CH_RESET;
            r.clear_armed          <= 1'b0;
            r.step                 <= 3'h0;
            r.pass_count           <= COUNT_RESET;
            r.conv_start           <= 1'b0;
            r.conv_channel         <= CH_RESET;
            r.prdata               <= 32'h0000_0000;
            r.pslverr              <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // zero wait states: every access phase completes in its first cycle
    assign pready                   = 1'b1;
    assign prdata                   = r.prdata;
    assign pslverr                  = r.pslverr && psel && penable;
    assign conv_start               = r.conv_start;
    assign conv_channel             = r.conv_channel;
    assign conversion_end_interrupt = r.conversion_end_flag && r.end_interrupt_enable;
endmodule // asb_top

// >>> test/adc_scan_buffer_sequencer_test.sv
// self-checking bench of the scan buffer sequencer
`timescale 1ns/10ps
module adc_scan_buffer_sequencer_test
    import asb_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        timer_trigger = 1'b0;
    logic        xfer_ctrl_active = 1'b0;
    logic [2:0]  lag = 3'h1;
    logic        pready, pslverr, conv_start, conv_done, irq, err;
    logic [31:0] prdata, rd;
    logic [2:0]  conv_channel;
    logic [9:0]  conv_result;
    logic [9:0]  expv [8] = '{default: 10'h000};
    int          cnt [8] = '{default: 0};
    int          err_total = 0;
    int          compares = 0;
    int          cycles = 0;
    always #10 clk = ~clk;
    asb_top i_asb_top (.*, .conversion_end_interrupt(irq));
    asb_conv_model i_asb_conv_model (.*);
    task automatic stop_test();
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] csr(input logic st, fg, ie, sc, gr, tr, input logic [1:0] m, input logic [2:0] c);
        logic [31:0] v;
        v = 32'h0;
        v[CSR_START_BIT] = st;
        v[CSR_FLAG_BIT] = fg;
        v[CSR_IE_BIT] = ie;
        v[CSR_SCAN_BIT] = sc;
        v[CSR_GROUP_BIT] = gr;
        v[CSR_TRIG_BIT] = tr;
        v[CSR_BUF_LSB +: 2] = m;
        v[CSR_CH_LSB +: 3] = c;
        return v;
    endfunction
    // one predicted conversion, shift first
    task automatic conv(input int c, input logic [1:0] m);
        if (c == 0 && m == BUF_FOUR) begin
            expv[3] = expv[2];
            expv[2] = expv[1];
            expv[1] = expv[0];
        end else if (c == 0 && m == BUF_TWO_ONE) begin
            expv[1] = expv[0];
        end else if (c < 2 && m == BUF_TWO_TWO) begin
            expv[c + 2] = expv[c];
        end
        expv[c] = {c[2:0], 7'(cnt[c])};
        cnt[c]++;
    endtask
    task automatic pass(input logic [1:0] m, input logic [2:0] c, output int fl);
        if (c[2] || (m == BUF_TWO_ONE && c[1])) begin
            conv(0, m);
            if (m == BUF_TWO_TWO) conv(1, m);
            for (int i = (m == BUF_TWO_ONE) ? 2 : 4; i <= c; i++) conv(i, m);
            fl = c;
        end else begin
            repeat ((m == BUF_TWO_TWO) ? c[1] + 1 : c[1:0] + 1) begin
                conv(0, m);
                if (m == BUF_TWO_TWO) conv(1, m);
            end
            fl = (m == BUF_TWO_TWO) ? (c[1] ? 3 : 1) : c[1:0];
        end
    endtask
    task automatic chk_res();
        for (int i = 0; i < NUM_RES; i++) begin
            apb(1'b0, RES_BASE + 8'(4 * i), 32'h0);
            chk(rd, {22'h0, expv[i]});
        end
    endtask
    // polling arms the flag clear
    task automatic wait_bit(input int b, input logic v);
        for (int k = 0; k < 200; k++) begin
            apb(1'b0, CSR_OFFSET, 32'h0);
            if (rd[b] === v) return;
        end
        chk(rd[b], v);
    endtask
    task automatic run(input logic [1:0] m, input logic [2:0] c, input logic dma);
        int fl;
        lag <= 3'(1 + $urandom % 6);
        apb(1'b1, CSR_OFFSET, csr(0, 0, 0, 0, 1, 0, BUF_NONE, c));
        apb(1'b1, CSR_OFFSET, csr(1, 0, 0, 0, 1, 0, m, c));
        pass(m, c, fl);
        wait_bit(CSR_START_BIT, 1'b0);
        chk(rd[CSR_FLAG_BIT], 1'b1);
        chk_res();
        if (dma) begin
            xfer_ctrl_active <= 1'b1;
            apb(1'b0, RES_BASE + 8'(4 * ((fl + 1) % 8)), 32'h0);
            apb(1'b0, CSR_OFFSET, 32'h0);
            chk(rd[CSR_FLAG_BIT], 1'b1);
            apb(1'b0, RES_BASE + 8'(4 * fl), 32'h0);
            apb(1'b0, CSR_OFFSET, 32'h0);
            chk(rd[CSR_FLAG_BIT], 1'b0);
            xfer_ctrl_active <= 1'b0;
        end else begin
            apb(1'b1, CSR_OFFSET, csr(0, 1, 0, 0, 1, 0, m, c));
            apb(1'b1, CSR_OFFSET, csr(0, 0, 0, 0, 1, 0, m, c));
            apb(1'b0, CSR_OFFSET, 32'h0);
            chk(rd[CSR_FLAG_BIT], 1'b1);
            apb(1'b1, CSR_OFFSET, csr(0, 0, 0, 0, 1, 0, m, c));
            apb(1'b0, CSR_OFFSET, 32'h0);
            chk(rd[CSR_FLAG_BIT], 1'b0);
        end
    endtask
    initial begin
        int fl;
        void'($urandom(32'h79A4));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, RES_BASE, 32'h3FF);
        chk(err, 1'b1);
        for (int m = 1; m < 4; m++) begin
            for (int c = 0; c < ((m == 1) ? 2 : 4); c++) run(2'(m), 3'(c), 1'b0);
        end
        run(BUF_TWO_ONE, 3'h2, 1'b0);
        run(BUF_TWO_ONE, 3'h3, 1'b0);
        run(BUF_FOUR, 3'h6, 1'b0);
        repeat (6) run(2'(1 + $urandom % 3), 3'(4 + $urandom % 4), 1'b0);
        run(BUF_TWO_TWO, 3'h5, 1'b1);
        apb(1'b1, CSR_OFFSET, csr(0, 0, 0, 0, 0, 0, BUF_NONE, 3'h1));
        apb(1'b1, CSR_OFFSET, csr(1, 0, 0, 0, 0, 0, BUF_FOUR, 3'h1));
        conv(0, BUF_FOUR);
        wait_bit(CSR_START_BIT, 1'b0);
        chk(rd[CSR_FLAG_BIT], 1'b0);
        apb(1'b1, CSR_OFFSET, csr(1, 0, 0, 0, 0, 1, BUF_FOUR, 3'h1));
        timer_trigger <= 1'b1;
        @(posedge clk);
        timer_trigger <= 1'b0;
        conv(0, BUF_FOUR);
        wait_bit(CSR_START_BIT, 1'b0);
        chk(rd[CSR_FLAG_BIT], 1'b1);
        chk_res();
        apb(1'b1, CSR_OFFSET, csr(0, 0, 0, 0, 0, 0, BUF_NONE, 3'h2));
        apb(1'b1, CSR_OFFSET, csr(1, 0, 0, 0, 0, 0, BUF_TWO_ONE, 3'h2));
        apb(1'b0, CSR_OFFSET, 32'h0);
        chk(rd[CSR_START_BIT], 1'b0);
        apb(1'b1, CSR_OFFSET, csr(0, 0, 0, 0, 1, 0, BUF_NONE, 3'h1));
        apb(1'b1, CSR_OFFSET, csr(1, 0, 1, 1, 1, 0, BUF_FOUR, 3'h1));
        pass(BUF_FOUR, 3'h1, fl);
        wait_bit(CSR_HOLD_BIT, 1'b1);
        chk(irq, 1'b1);
        chk(rd[CSR_START_BIT], 1'b1);
        repeat (20) @(posedge clk);
        chk_res();
        apb(1'b1, CSR_OFFSET, csr(1, 0, 1, 1, 1, 0, BUF_FOUR, 3'h1));
        pass(BUF_FOUR, 3'h1, fl);
        wait_bit(CSR_HOLD_BIT, 1'b1);
        chk_res();
        apb(1'b1, CSR_OFFSET, csr(0, 0, 1, 1, 1, 0, BUF_FOUR, 3'h1));
        apb(1'b0, CSR_OFFSET, 32'h0);
        chk({rd[CSR_START_BIT], irq}, 2'b00);
        stop_test();
    end
endmodule // adc_scan_buffer_sequencer_test

// >>> test/asb_conv_model.sv
// analog core stand-in answering each request after a set lag
`timescale 1ns/10ps
module asb_conv_model
    import asb_pkg::*;
(
    input wire logic              clk,
    input wire logic              conv_start,
    input wire logic [2:0]        conv_channel,
    input wire logic [2:0]        lag,
    output logic                  conv_done,
    output logic     [DATA_W-1:0] conv_result
);
    int         n [8] = '{default: 0};
    logic [9:0] v;
    initial begin
        conv_done = 1'b0;
        conv_result = 10'h3FF;
        forever begin
            @(posedge clk);
            if (conv_start === 1'b1) begin
                v = {conv_channel, 7'(n[conv_channel])};
                n[conv_channel]++;
                repeat (lag) @(posedge clk);
                conv_done <= 1'b1;
                conv_result <= v;
                @(posedge clk);
                conv_done <= 1'b0;
                // bus not held past the strobe
                conv_result <= ~v;
            end
        end
    end
endmodule // asb_conv_model

// >>> test/asb_monitor.sv
// port assertions of the sequencer top
`timescale 1ns/10ps
module asb_monitor
    import asb_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        xfer_ctrl_active,
    input wire logic        conv_start,
    input wire logic [2:0]  conv_channel,
    input wire logic        conv_done,
    input wire logic        conversion_end_interrupt
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_acc; psel && penable; endsequence
    sequence s_res_wr; s_acc ##0 (pwrite && paddr[7:5] == RES_PAGE); endsequence
    sequence s_bad_rd; s_acc ##0 (!pwrite && pslverr); endsequence
    // one conversion outstanding, so requests never crowd
    req_spacing_a: assert property (conv_start |=> !conv_start [*2])
        else $error("requests too close");
    done_gap_a: assert property (conv_done |=> !conv_start)
        else $error("request right after done");
    irq_cause_a: assert property ($rose(conversion_end_interrupt) |-> $past(conv_done) || $past(psel && penable && pwrite))
        else $error("interrupt without cause");
    hold_quiet_a: assert property (conversion_end_interrupt |-> !conv_start)
        else $error("request while held");
    irq_clear_a: assert property ($fell(conversion_end_interrupt) |-> $past(psel && penable && (pwrite || xfer_ctrl_active)))
        else $error("interrupt dropped without access");
    chan_hold_a: assert property ($changed(conv_channel) |-> conv_start)
        else $error("channel moved between requests");
    res_ro_a: assert property (s_res_wr |-> pslverr)
        else $error("result write accepted");
    unmapped_zero_a: assert property (s_bad_rd |-> prdata == 32'h0)
        else $error("refused read data not zero");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule // asb_monitor
bind asb_top asb_monitor i_asb_monitor (.*);
